//--- hdl/udp_pkg.sv
package udp_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int CNT_W = 16;
  localparam int ACT_W = 8;
  localparam int CTL_W = 3;
  localparam int DB_W = 12;
  localparam int MASK_W = 2;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  // Two-bit action fields inside output_action_a
  localparam int ACT_ZERO_LSB = 0;
  localparam int ACT_LOAD_LSB = 2;
  localparam int ACT_CMPU_LSB = 4;
  localparam int ACT_CMPD_LSB = 6;
  // Bits of generator_control
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_UPDOWN_BIT = 1;
  localparam int CTL_DEBUG_BIT = 2;
  // Bit of deadband_control
  localparam int DB_ENABLE_BIT = 0;
  localparam int DB_CTL_W = 1;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_INVERT = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  // enable_update_bits modes
  localparam logic [1:0] UPD_IMMEDIATE = 2'h0;
  localparam logic [1:0] UPD_LOCAL = 2'h2;
  localparam logic [1:0] UPD_GLOBAL = 2'h3;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic OUT_RST = 1'b0;
  localparam logic [MASK_W-1:0] MASK_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DB_W-1:0] DB_CNT_RST = 12'h000;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic [CNT_W-1:0] period_load_value;
    logic [CNT_W-1:0] compare_a_value;
    logic [ACT_W-1:0] output_action_a;
    logic [CTL_W-1:0] generator_control;
  } udp_gen_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic count_down;
    logic zero_pulse;
    logic load_pulse;
  } udp_gen_status_t;

  typedef enum logic [1:0] {
    UDP_DB_IDLE,
    UDP_DB_RISE,
    UDP_DB_FALL
  } udp_db_state_t;

endpackage

//--- hdl/udp_pwm_gen.sv
`timescale 1ns/100ps

module udp_pwm_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Generator configuration
  input wire udp_pkg::udp_gen_cfg_t gen_cfg,
  input wire logic debug_halt,
  // Time-base sync write strobe
  input wire logic time_base_sync,
  // Output enables and their update mode
  input wire logic [udp_pkg::MASK_W-1:0] output_enable_mask,
  input wire logic [1:0] enable_update_bits,
  input wire logic global_update,
  // Dead-band setup
  input wire logic [udp_pkg::DB_CTL_W-1:0] deadband_control,
  input wire logic [udp_pkg::DB_W-1:0] deadband_rise_delay,
  input wire logic [udp_pkg::DB_W-1:0] deadband_fall_delay,
  // Pins and status
  output logic pwm_out_a,
  output logic pwm_out_b,
  output udp_pkg::udp_gen_status_t gen_status
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Apply one two-bit action code to the current level
  function automatic logic act_apply(input logic cur, input logic [1:0] code);
    logic res;
    res = cur;
    case (code)
      udp_pkg::ACT_INVERT: res = ~cur;
      udp_pkg::ACT_LOW: res = 1'b0;
      udp_pkg::ACT_HIGH: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  // ***************************************************************
  // Counter
  // ***************************************************************
  logic [udp_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic down_q, down_d;
  logic en, updown, run;
  logic [udp_pkg::CNT_W-1:0] load, cmpa;
  logic [udp_pkg::ACT_W-1:0] act;

  assign load = gen_cfg.period_load_value;
  assign cmpa = gen_cfg.compare_a_value;
  assign act = gen_cfg.output_action_a;
  assign en = gen_cfg.generator_control[udp_pkg::CTL_ENABLE_BIT];
  assign updown = gen_cfg.generator_control[udp_pkg::CTL_UPDOWN_BIT];
  // Debug bit set keeps the counter running while the core is halted
  assign run = en & ~(debug_halt & ~gen_cfg.generator_control[udp_pkg::CTL_DEBUG_BIT]);

  // Next count; both ends are held for two clocks in up/down mode
  always_comb begin
    cnt_d = cnt_q;
    down_d = down_q;
    if (!en) begin
      cnt_d = udp_pkg::CNT_RST;
      down_d = 1'b0;
    end else if (time_base_sync) begin
      cnt_d = udp_pkg::CNT_RST;
      down_d = 1'b0;
    end else if (run) begin
      if (updown) begin
        if (!down_q) begin
          if (cnt_q >= load) begin
            down_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end else begin
          if (cnt_q == udp_pkg::CNT_RST) begin
            down_d = 1'b0;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      end else begin
        down_d = 1'b1;
        if (cnt_q == udp_pkg::CNT_RST) begin
          cnt_d = load;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
    end
  end

  // Counter state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= udp_pkg::CNT_RST;
      down_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      down_q <= down_d;
    end
  end

  // ***************************************************************
  // Events
  // ***************************************************************
  logic zero_evt, load_evt, cmpu_evt, cmpd_evt;

  // Sync counts as a zero; nothing fires while disabled
  assign zero_evt = en & (time_base_sync | (run & (cnt_d == udp_pkg::CNT_RST) &
                    (cnt_q != udp_pkg::CNT_RST)));
  assign load_evt = run & ~time_base_sync & (cnt_d == load) & (cnt_q != load);
  // Rising match acts as the count leaves the compare value
  assign cmpu_evt = run & ~time_base_sync & updown & ~down_q & (cnt_q == cmpa);
  // Falling match acts as the count enters the compare value
  assign cmpd_evt = run & ~time_base_sync & down_d & (cnt_d == cmpa) &
                    ~((cnt_q == cmpa) & down_q);

  // ***************************************************************
  // Generator A output
  // ***************************************************************
  logic gen_a_q, gen_a_d;
  logic zero_pulse_q, load_pulse_q;

  // Compare actions win over zero and load in the same cycle
  always_comb begin
    gen_a_d = gen_a_q;
    if (zero_evt) begin
      gen_a_d = act_apply(gen_a_d, act[udp_pkg::ACT_ZERO_LSB +: 2]);
    end
    if (load_evt) begin
      gen_a_d = act_apply(gen_a_d, act[udp_pkg::ACT_LOAD_LSB +: 2]);
    end
    if (cmpu_evt) begin
      gen_a_d = act_apply(gen_a_d, act[udp_pkg::ACT_CMPU_LSB +: 2]);
    end
    if (cmpd_evt) begin
      gen_a_d = act_apply(gen_a_d, act[udp_pkg::ACT_CMPD_LSB +: 2]);
    end
    if (!en) begin
      gen_a_d = udp_pkg::OUT_RST;
    end
  end

  // Output level and one-cycle status pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_a_q <= udp_pkg::OUT_RST;
      zero_pulse_q <= 1'b0;
      load_pulse_q <= 1'b0;
    end else begin
      gen_a_q <= gen_a_d;
      zero_pulse_q <= zero_evt;
      load_pulse_q <= load_evt;
    end
  end

  // Status packed in one place so the struct has a single driver
  assign gen_status = '{count: cnt_q, count_down: down_q,
                        zero_pulse: zero_pulse_q, load_pulse: load_pulse_q};

  // ***************************************************************
  // Output enable update
  // ***************************************************************
  logic [udp_pkg::MASK_W-1:0] mask_q;

  // Deferred modes let several generators switch on at the same instant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= udp_pkg::MASK_RST;
    end else begin
      case (enable_update_bits)
        udp_pkg::UPD_LOCAL: begin
          if (zero_evt) begin
            mask_q <= output_enable_mask;
          end
        end
        udp_pkg::UPD_GLOBAL: begin
          if (global_update) begin
            mask_q <= output_enable_mask;
          end
        end
        default: begin
          mask_q <= output_enable_mask;
        end
      endcase
    end
  end

  // ***************************************************************
  // Dead-band stage
  // ***************************************************************
  udp_pkg::udp_db_state_t db_state_q;
  logic [udp_pkg::DB_W-1:0] db_cnt_q;
  logic db_a_q, db_b_q, db_prev_q, db_en;

  assign db_en = deadband_control[udp_pkg::DB_ENABLE_BIT];

  // Delays each edge; the stage tracks A even when bypassed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      db_state_q <= udp_pkg::UDP_DB_IDLE;
      db_cnt_q <= udp_pkg::DB_CNT_RST;
      db_a_q <= udp_pkg::OUT_RST;
      db_b_q <= udp_pkg::OUT_RST;
      db_prev_q <= udp_pkg::OUT_RST;
    end else begin
      db_prev_q <= gen_a_q;
      if (gen_a_q && !db_prev_q) begin
        db_b_q <= 1'b0;
        db_cnt_q <= deadband_rise_delay;
        db_state_q <= udp_pkg::UDP_DB_RISE;
      end else if (!gen_a_q && db_prev_q) begin
        db_a_q <= 1'b0;
        db_cnt_q <= deadband_fall_delay;
        db_state_q <= udp_pkg::UDP_DB_FALL;
      end else begin
        case (db_state_q)
          udp_pkg::UDP_DB_RISE: begin
            if (db_cnt_q == udp_pkg::DB_CNT_RST) begin
              db_a_q <= 1'b1;
              db_state_q <= udp_pkg::UDP_DB_IDLE;
            end else begin
              db_cnt_q <= db_cnt_q - 12'h001;
            end
          end
          udp_pkg::UDP_DB_FALL: begin
            if (db_cnt_q == udp_pkg::DB_CNT_RST) begin
              db_b_q <= 1'b1;
              db_state_q <= udp_pkg::UDP_DB_IDLE;
            end else begin
              db_cnt_q <= db_cnt_q - 12'h001;
            end
          end
          default: db_state_q <= udp_pkg::UDP_DB_IDLE;
        endcase
      end
    end
  end

  // ***************************************************************
  // Pins
  // ***************************************************************
  // Bypass adds no delay: gating flops only, no extra register stage
  assign pwm_out_a = mask_q[0] & (db_en ? db_a_q : gen_a_q);
  assign pwm_out_b = mask_q[1] & (db_en ? db_b_q : 1'b0);

endmodule

//--- dv/udp_pwm_gen_asserts.sv
`timescale 1ns/100ps
module udp_pwm_gen_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched inputs
  input wire udp_pkg::udp_gen_cfg_t gen_cfg,
  input wire logic time_base_sync,
  input wire logic [udp_pkg::MASK_W-1:0] output_enable_mask,
  input wire logic [1:0] enable_update_bits,
  input wire logic [udp_pkg::DB_CTL_W-1:0] deadband_control,
  // Watched outputs
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire udp_pkg::udp_gen_status_t gen_status
);
  // ****************************************
  // Helpers
  // ****************************************
  logic en;
  logic run;
  logic calm;
  logic dn;
  logic [udp_pkg::CNT_W-1:0] cnt;
  logic [udp_pkg::CNT_W-1:0] ld;
  logic [udp_pkg::CNT_W-1:0] cmp;
  // Run also needs debug-run set, since the halt input is not watched here
  assign en = gen_cfg.generator_control[udp_pkg::CTL_ENABLE_BIT];
  assign run = en && gen_cfg.generator_control[udp_pkg::CTL_UPDOWN_BIT] &&
               gen_cfg.generator_control[udp_pkg::CTL_DEBUG_BIT];
  assign cnt = gen_status.count;
  assign dn = gen_status.count_down;
  assign ld = gen_cfg.period_load_value;
  assign cmp = gen_cfg.compare_a_value;
  // Direct pin with immediate mask; other modes would fake pin edges
  assign calm = en && deadband_control == 1'h0 && output_enable_mask[0] &&
                enable_update_bits == 2'h0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // Assertions
  // ****************************************
  AST_UP_STEP: assert property (run && !time_base_sync && !dn && cnt < ld
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not climb");
  AST_TOP_TURN: assert property (run && !time_base_sync && !dn && cnt == ld
    |=> cnt == $past(cnt) && dn)
    else $error("counter did not turn at load");
  AST_DOWN_STEP: assert property (run && !time_base_sync && dn && cnt != 16'h0000
    |=> cnt == $past(cnt) - 16'h0001)
    else $error("counter did not descend");
  AST_DOWN_MATCH: assert property (calm && $stable(output_enable_mask)
    && gen_cfg.output_action_a == 8'hB0 && dn && $past(dn) && cnt == cmp
    && $past(cnt) == cmp + 16'h0001 |-> !pwm_out_a)
    else $error("falling match left pin high");
  AST_HIGH_WIDTH: assert property (calm && $stable(output_enable_mask)
    && cmp == ld - 16'h0001 && $rose(pwm_out_a) |-> ##1 pwm_out_a ##1 !pwm_out_a)
    else $error("high pulse not two clocks");
  AST_LOW_WIDTH: assert property (calm && $stable(output_enable_mask)
    && cmp == 16'h0001 && $fell(pwm_out_a) |-> !pwm_out_a [*4] ##1 pwm_out_a)
    else $error("low pulse wrong width");
  AST_SYNC_ZERO: assert property (time_base_sync && en
    |=> cnt == 16'h0000 && !dn && gen_status.zero_pulse)
    else $error("sync did not clear counter");
  AST_SYNC_ACT: assert property (time_base_sync && calm && $stable(output_enable_mask)
    && cmp != 16'h0000 && gen_cfg.output_action_a[1:0] == udp_pkg::ACT_LOW
    |=> !pwm_out_a)
    else $error("sync skipped zero action");
  AST_ZERO_EN: assert property (gen_status.zero_pulse
    |-> cnt == 16'h0000 && $past(en))
    else $error("zero pulse without enable");
  AST_OFF_QUIET: assert property (!en
    |=> !gen_status.zero_pulse && cnt == 16'h0000)
    else $error("disabled generator active");
  AST_B_BYPASS: assert property (deadband_control == 1'h0
    && $past(deadband_control) == 1'h0 |-> !pwm_out_b)
    else $error("pin b driven in bypass");
  // Main scenarios
  cover property (gen_status.zero_pulse && !time_base_sync);
  cover property (time_base_sync && en);
  cover property ($rose(pwm_out_a));
endmodule

bind udp_pwm_gen udp_pwm_gen_chk chk (.clk(clk), .rst(rst), .gen_cfg(gen_cfg),
  .time_base_sync(time_base_sync), .output_enable_mask(output_enable_mask),
  .enable_update_bits(enable_update_bits), .deadband_control(deadband_control),
  .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .gen_status(gen_status));

//--- dv/udp_pwm_gen_tb.sv
`timescale 1ns/100ps
module udp_pwm_gen_tb;
  // ****************************************
  // Stimulus and counters
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  udp_pkg::udp_gen_cfg_t cfg;
  logic sync = 1'b0;
  logic [1:0] mask = 2'h1;
  logic [1:0] upd = 2'h0;
  logic glob = 1'b0;
  logic db = 1'b0;
  logic pa;
  logic pb;
  udp_pkg::udp_gen_status_t st;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int per;
  int hi;
  always #5 clk = ~clk;
  // Halt and dead-band delays stay fixed; the dead-band path is only checked at zero delay
  udp_pwm_gen dut (.clk(clk), .rst(rst), .gen_cfg(cfg), .debug_halt(1'b0),
    .time_base_sync(sync), .output_enable_mask(mask), .enable_update_bits(upd),
    .global_update(glob), .deadband_control(db), .deadband_rise_delay(12'h000),
    .deadband_fall_delay(12'h000), .pwm_out_a(pa), .pwm_out_b(pb), .gen_status(st));
  // Tests need about 2000 cycles; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      test_done();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Inputs move 1 ns after the edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_zero();
    int i;
    i = 0;
    tick(1);
    while (st.zero_pulse !== 1'b1 && i < 500) begin
      tick(1);
      i++;
    end
    check(i < 500, "no zero event");
  endtask
  // Runs until the counter shows a value in the given direction
  task automatic wait_count(input logic [15:0] v, input logic d);
    int i;
    i = 0;
    while ((st.count !== v || st.count_down !== d) && i < 500) begin
      tick(1);
      i++;
    end
    check(i < 500, "count not reached");
  endtask
  // One period between zero events; trailing wait clears the pulse window
  task automatic measure();
    wait_zero();
    per = 0;
    hi = 0;
    do begin
      tick(1);
      per++;
      hi += int'(pa === 1'b1);
    end while (st.zero_pulse !== 1'b1 && per < 500);
    tick(20);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pulses();
    measure();
    check(per == 200, "period");
    check(hi == 2, "high width");
    check(pb === 1'b0, "pin b");
    cfg.compare_a_value = 16'h0001;
    measure();
    check(hi == 196, "low width");
    $display("t_pulses done");
  endtask
  task automatic t_sync();
    int i;
    i = 0;
    // Mid-range compare keeps clear of the values older parts mishandle
    cfg.compare_a_value = 16'h000A;
    cfg.output_action_a = 8'hB2;
    wait_zero();
    while (st.count !== 16'h0032 && i < 200) begin
      tick(1);
      i++;
    end
    check(pa === 1'b1, "high after rising match");
    sync = 1'b1;
    tick(1);
    sync = 1'b0;
    check(st.count === 16'h0000 && st.zero_pulse === 1'b1, "sync clear");
    check(pa === 1'b0, "zero action on sync");
    $display("t_sync done");
  endtask
  task automatic t_enupd();
    cfg.output_action_a = 8'h03;
    mask = 2'h0;
    wait_zero();
    upd = udp_pkg::UPD_GLOBAL;
    mask = 2'h1;
    tick(5);
    check(pa === 1'b0, "mask held until global update");
    glob = 1'b1;
    tick(1);
    glob = 1'b0;
    check(pa === 1'b1, "mask taken on global update");
    upd = udp_pkg::UPD_LOCAL;
    mask = 2'h0;
    tick(3);
    check(pa === 1'b1, "mask held until zero");
    wait_zero();
    tick(1);
    check(pa === 1'b0, "mask taken on zero");
    upd = udp_pkg::UPD_IMMEDIATE;
    mask = 2'h1;
    $display("t_enupd done");
  endtask
  // Dead-band on delays pin a and fills pin b; all-zero control passes A straight through and holds pin b low
  task automatic t_dband();
    cfg.output_action_a = 8'hB0;
    cfg.compare_a_value = 16'h0062;
    mask = 2'h3;
    db = 1'b1;
    wait_zero();
    wait_count(16'h0062, 1'b0);
    check(pb === 1'b1, "pin b complements low a");
    tick(1);
    check(st.count === 16'h0063 && pa === 1'b0, "dead band delays rise");
    check(st.load_pulse === 1'b1, "load pulse at top");
    wait_count(16'h0050, 1'b1);
    db = 1'b0;
    tick(1);
    check(pa === 1'b0 && pb === 1'b0, "bypass drops pin b");
    mask = 2'h1;
    $display("t_dband done");
  endtask
  task automatic t_off();
    int bad;
    bad = 0;
    cfg.generator_control = 3'h6;
    repeat (250) begin
      tick(1);
      bad += int'(st.zero_pulse !== 1'b0 || pa !== 1'b0);
    end
    check(bad == 0, "activity while disabled");
    $display("t_off done");
  endtask
  initial begin
    cfg = '{16'h0063, 16'h0062, 8'hB0, 3'h7};
    tick(10);
    rst = 1'b0;
    t_pulses();
    t_sync();
    t_enupd();
    t_dband();
    t_off();
    test_done();
  end
endmodule
